// ===== verif/ecp_host_model.sv
// APB master standing in for the host controller that reads the card properties
`timescale 1ns/10ps
`default_nettype none
module ecp_host_model (
	// Clock
	input wire logic pclk,
	// APB answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// APB request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	// Idle bus at time zero
	initial
	begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end

	// One transfer, entered just after a rising edge; keep leaves psel up for an immediate setup
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic keep,
		output logic [31:0] rd, output logic er);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Request held until pready is seen at an edge
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		if (!keep)
		begin
			psel <= 1'h0;
			penable <= 1'h0;
			paddr <= ~a; // Released lines stop showing the old value
			pwdata <= ~d;
		end
	endtask
endmodule
`default_nettype wire

// ===== verif/ecp_prop_bank_test.sv
// Self-checking bench for the card property register bank
`timescale 1ns/10ps
`default_nettype none
module ecp_prop_bank_test;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	typedef struct packed {logic b; logic w; logic [11:0] a; logic [7:0] e; logic r;} ecp_row_type;
	logic pclk, presetn, sel_b, psel, penable, pwrite, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, prdata_a, prdata_b, rd;
	logic psel_a, psel_b, pready, pready_a, pready_b, pslverr, pslverr_a, pslverr_b;
	logic [7:0] ext_a, ext_b;
	int n_errors, check_count;
	// Rows: device, write, address, read value or write data, error
	ecp_row_type rows [38] = '{
		'{1'h0,1'h0,12'h334,8'h1e,1'h0}, '{1'h0,1'h0,12'h338,8'h1e,1'h0},
		'{1'h0,1'h0,12'h33c,8'h46,1'h0}, '{1'h0,1'h0,12'h340,8'h46,1'h0},
		'{1'h0,1'h0,12'h344,8'h50,1'h0}, '{1'h0,1'h0,12'h348,8'h50,1'h0},
		'{1'h0,1'h0,12'h320,8'h43,1'h0}, '{1'h0,1'h0,12'h324,8'h21,1'h0},
		'{1'h0,1'h0,12'h328,8'h43,1'h0}, '{1'h0,1'h0,12'h32c,8'h21,1'h0},
		'{1'h0,1'h0,12'h310,8'h03,1'h0}, '{1'h0,1'h0,12'h308,8'h02,1'h0},
		'{1'h0,1'h0,12'h30c,8'h00,1'h0}, '{1'h0,1'h0,12'h000,8'h00,1'h0},
		'{1'h1,1'h0,12'h334,8'h1e,1'h0}, '{1'h1,1'h0,12'h338,8'h28,1'h0},
		'{1'h1,1'h0,12'h33c,8'h46,1'h0}, '{1'h1,1'h0,12'h340,8'h64,1'h0},
		'{1'h1,1'h0,12'h344,8'h00,1'h0}, '{1'h1,1'h0,12'h348,8'h8c,1'h0},
		'{1'h1,1'h0,12'h320,8'h00,1'h0}, '{1'h1,1'h0,12'h324,8'h02,1'h0},
		'{1'h1,1'h0,12'h328,8'h00,1'h0}, '{1'h1,1'h0,12'h32c,8'h01,1'h0},
		'{1'h1,1'h0,12'h310,8'h01,1'h0}, '{1'h1,1'h0,12'h308,8'h02,1'h0},
		'{1'h0,1'h1,12'h334,8'hff,1'h1}, '{1'h0,1'h0,12'h334,8'h1e,1'h0},
		'{1'h0,1'h0,12'h400,8'h01,1'h0}, '{1'h0,1'h1,12'h404,8'h01,1'h0},
		'{1'h0,1'h0,12'h400,8'h00,1'h0}, '{1'h0,1'h0,12'h404,8'h00,1'h0},
		'{1'h0,1'h1,12'h400,8'h01,1'h1}, '{1'h0,1'h0,12'h335,8'h00,1'h1},
		'{1'h0,1'h0,12'h408,8'h00,1'h1}, '{1'h0,1'h1,12'h408,8'h01,1'h1},
		'{1'h0,1'h0,12'h400,8'h01,1'h0}, '{1'h0,1'h1,12'h404,8'h01,1'h0}
	};

	// ----------------------------------------
	// Bus sharing between the two devices
	// ----------------------------------------
	assign psel_a = psel & ~sel_b;
	assign psel_b = psel & sel_b;
	assign prdata = sel_b ? prdata_b : prdata_a;
	assign pready = sel_b ? pready_b : pready_a;
	assign pslverr = sel_b ? pslverr_b : pslverr_a;

	// Clock
	always #2 pclk = ~pclk;

	// ----------------------------------------
	// Instances
	// ----------------------------------------
	ecp_host_model i_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	ecp_prop_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel_a), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata_a), .pready(pready_a), .pslverr(pslverr_a),
		.layout_version_ext(ext_a));
	// Awkward card: illegal and oversized codes, 26MHz only
	ecp_prop_bank #(.RAW_PERF({8'h8c, 8'h33, 8'h64, 8'h00, 8'h28, 8'h08}),
		.RAW_PWR({8'hb1, 8'h3c, 8'hf2, 8'h55}), .HS52(1'h0), .RAW_LAYOUT(8'h05)) i_dut_b (.pclk(pclk),
		.presetn(presetn), .psel(psel_b), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata_b), .pready(pready_b), .pslverr(pslverr_b), .layout_version_ext(ext_b));

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial
	begin
		#20000;
		n_errors++;
		$display("watchdog expired");
		conclude();
	end

	// Main sequence
	initial
	begin
		pclk = 1'h0;
		presetn = 1'h0;
		sel_b = 1'h0;
		n_errors = 0;
		check_count = 0;
		repeat (10) @(posedge pclk);
		chk("pready in reset", 32'h0, {31'h0, pready_a});
		chk("prdata in reset", 32'h0, prdata_a);
		chk("ext in reset", 32'h0, {24'h0, ext_a});
		presetn <= 1'h1;
		repeat (3) @(posedge pclk);
		chk("layout ext a", 32'h2, {24'h0, ext_a});
		chk("layout ext b", 32'h2, {24'h0, ext_b});
		$display("test reset done");
		foreach (rows[i])
		begin
			sel_b <= rows[i].b;
			@(posedge pclk);
			i_host.xfer(rows[i].w, rows[i].a, {24'h0, rows[i].e}, 1'h0, rd, er);
			if (rows[i].w == 1'h0)
				chk($sformatf("row %0d data", i), {24'h0, rows[i].e}, rd);
			chk($sformatf("row %0d error", i), {31'h0, rows[i].r}, {31'h0, er});
		end
		$display("test table done");
		// Back-to-back reads with no idle cycle
		@(posedge pclk);
		i_host.xfer(1'h0, 12'h310, 32'h0, 1'h1, rd, er);
		chk("b2b speed", 32'h3, rd);
		i_host.xfer(1'h0, 12'h308, 32'h0, 1'h0, rd, er);
		chk("b2b layout", 32'h2, rd);
		$display("test back to back done");
		// Refused write flags, then a mid-run reset clears the flag
		@(posedge pclk);
		i_host.xfer(1'h1, 12'h310, 32'hff, 1'h1, rd, er);
		chk("speed write error", 32'h1, {31'h0, er});
		i_host.xfer(1'h0, 12'h400, 32'h0, 1'h0, rd, er);
		chk("flag before reset", 32'h1, rd);
		presetn <= 1'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		repeat (2) @(posedge pclk);
		i_host.xfer(1'h0, 12'h400, 32'h0, 1'h1, rd, er);
		chk("flag after reset", 32'h0, rd);
		i_host.xfer(1'h0, 12'h310, 32'h0, 1'h0, rd, er);
		chk("speed after reset", 32'h3, rd);
		$display("test refused write and reset done");
		conclude();
	end
endmodule
`default_nettype wire

// ===== verilog/ecp_perf_filter.sv
// Legalises the six minimum throughput codes
`default_nettype none
`timescale 1ns/10ps
module ecp_perf_filter (
	// Raw codes: 0 R4@26, 1 W4@26, 2 R mid, 3 W mid, 4 R8@52, 5 W8@52
	input wire logic [5:0][7:0] raw_code,
	// Legal codes
	output logic [5:0][7:0] minimum_throughput_code
);
	logic [5:0][7:0] legal_code;
	logic [5:0] above_mid;
	logic any_above;

	// Illegal codes fall back to the no-class code
	genvar i;
	generate
		for (i = 0; i < 6; i++)
		begin : g_code
			assign legal_code[i] = ecp_pkg::perf_legal(raw_code[i]) ?
				raw_code[i] : ecp_pkg::PERF_NONE; // see [R1] see [R4] see [R14]
			assign above_mid[i] = legal_code[i] > ecp_pkg::PERF_J; // see [R2]
		end
	endgenerate

	assign any_above = |above_mid;

	// High classes force mid and low category floors
	always_comb
	begin
		minimum_throughput_code = legal_code;
		if (any_above)
		begin
			if (legal_code[0] < ecp_pkg::PERF_E) minimum_throughput_code[0] = ecp_pkg::PERF_E; // see [R3]
			if (legal_code[1] < ecp_pkg::PERF_E) minimum_throughput_code[1] = ecp_pkg::PERF_E; // see [R3]
			if (legal_code[2] < ecp_pkg::PERF_J) minimum_throughput_code[2] = ecp_pkg::PERF_J; // see [R3]
			if (legal_code[3] < ecp_pkg::PERF_J) minimum_throughput_code[3] = ecp_pkg::PERF_J; // see [R3]
		end
	end
endmodule
`default_nettype wire

// ===== verilog/ecp_pkg.sv
// Constants shared by the extended card property register bank
`default_nettype none
package ecp_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 x index)
	// ----------------------------------------
	localparam logic [9:0] IDX_PERF_R_4_26 = 10'h0cd;
	localparam logic [9:0] IDX_PERF_W_4_26 = 10'h0ce;
	localparam logic [9:0] IDX_PERF_R_MID = 10'h0cf;
	localparam logic [9:0] IDX_PERF_W_MID = 10'h0d0;
	localparam logic [9:0] IDX_PERF_R_8_52 = 10'h0d1;
	localparam logic [9:0] IDX_PERF_W_8_52 = 10'h0d2;
	localparam logic [9:0] IDX_PWR_52_195 = 10'h0c8;
	localparam logic [9:0] IDX_PWR_26_195 = 10'h0c9;
	localparam logic [9:0] IDX_PWR_52_360 = 10'h0ca;
	localparam logic [9:0] IDX_PWR_26_360 = 10'h0cb;
	localparam logic [9:0] IDX_SPEED = 10'h0c4;
	localparam logic [9:0] IDX_LAYOUT = 10'h0c2;
	localparam logic [9:0] IDX_BLOCK_END = 10'h100;
	localparam logic [9:0] IDX_STATUS = 10'h100;
	localparam logic [9:0] IDX_CTRL = 10'h101;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int STAT_WVIOL_BIT = 0;
	localparam int CTRL_CLR_BIT = 0;
	localparam logic RST_WVIOL = 1'b0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// ----------------------------------------
	// Throughput codes, steps of 300 kB/s
	// ----------------------------------------
	localparam logic [7:0] PERF_NONE = 8'h00;
	localparam logic [7:0] PERF_A = 8'h08;
	localparam logic [7:0] PERF_B = 8'h0a;
	localparam logic [7:0] PERF_C = 8'h0f;
	localparam logic [7:0] PERF_D = 8'h14;
	localparam logic [7:0] PERF_E = 8'h1e;
	localparam logic [7:0] PERF_F = 8'h28;
	localparam logic [7:0] PERF_G = 8'h32;
	localparam logic [7:0] PERF_H = 8'h3c;
	localparam logic [7:0] PERF_J = 8'h46;
	localparam logic [7:0] PERF_K = 8'h50;
	localparam logic [7:0] PERF_M = 8'h64;
	localparam logic [7:0] PERF_O = 8'h78;
	localparam logic [7:0] PERF_R = 8'h8c;

	// ----------------------------------------
	// Power class, speed and layout codes
	// ----------------------------------------
	localparam logic [3:0] PWR_DEFAULT = 4'h0;
	localparam logic [3:0] PWR_MAX = 4'ha;
	localparam logic [7:0] SPEED_26 = 8'h01;
	localparam logic [7:0] SPEED_26_52 = 8'h03;
	localparam logic [7:0] LAYOUT_MAX = 8'h02;

	// Legal throughput code check
	function automatic logic perf_legal(input logic [7:0] c);
		perf_legal = (c == PERF_NONE) || (c == PERF_A) || (c == PERF_B) ||
			(c == PERF_C) || (c == PERF_D) || (c == PERF_E) ||
			(c == PERF_F) || (c == PERF_G) || (c == PERF_H) ||
			(c == PERF_J) || (c == PERF_K) || (c == PERF_M) ||
			(c == PERF_O) || (c == PERF_R);
	endfunction

endpackage
`default_nettype wire

// ===== verilog/ecp_power_filter.sv
// Legalises the four power class bytes
`default_nettype none
`timescale 1ns/10ps
module ecp_power_filter (
	// Raw bytes: 0 52@1.95, 1 26@1.95, 2 52@3.6, 3 26@3.6
	input wire logic [3:0][7:0] raw_class,
	input wire logic hs52,
	// Legal bytes, upper nibble 8-line, lower nibble 4-line
	output logic [3:0][7:0] power_class_by_width
);
	// One nibble at a time; even bytes are the fast clock fields
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_nib
			logic [3:0] nib;
			assign nib = raw_class[i / 2][(i % 2) * 4 +: 4]; // see [R5]
			assign power_class_by_width[i / 2][(i % 2) * 4 +: 4] =
				((((i / 2) % 2) == 0) && !hs52) ? ecp_pkg::PWR_DEFAULT : // see [R8]
				(nib > ecp_pkg::PWR_MAX) ? ecp_pkg::PWR_DEFAULT : nib; // see [R7]
		end
	endgenerate
endmodule
`default_nettype wire

// ===== verilog/ecp_prop_bank.sv
// APB register bank holding the card property fields
//
// What this block does
// [R1] Codes 0x28/0x32/0x3C for 12/15/18 MB/s
// [R2] Code 0x46 is mid category top
// [R3] Above 0x46 implies mid 0x46, low 0x1E
// [R4] Codes 0x50..0x8C; other codes illegal
// [R5] Upper nibble 8-line, lower 4-line current
// [R6] One-line bus fits default class zero
// [R7] Power codes above ten never reported
// [R8] Fast clock power fields zero when 26MHz-only
// [R9] Speed byte is only 0x01 or 0x03
// [R10] Bit0 26MHz high speed, bit1 52MHz
// [R11] Layout byte extends basic version field
// [R12] Layout version 0..2, rest reserved
// [R13] Reserved bits and bytes read zero
// [R14] Code 0x00 means below 2.4 MB/s
// [R15] Properties fixed; writes refused and flagged
//
// Chosen here: the APB interface to the registers and the address map.
`default_nettype none
`timescale 1ns/10ps
module ecp_prop_bank #(
	parameter logic [5:0][7:0] RAW_PERF = {8'h50, 8'h50, 8'h46, 8'h46, 8'h1e, 8'h1e},
	parameter logic [3:0][7:0] RAW_PWR = {8'h21, 8'h43, 8'h21, 8'h43},
	parameter logic HS52 = 1'b1,
	parameter logic [7:0] RAW_LAYOUT = 8'h02
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB request
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// APB answer
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Version extension toward the basic config register
	output logic [7:0] layout_version_ext
);

	// ----------------------------------------
	// Property fields
	// ----------------------------------------
	logic [5:0][7:0] perf_legal_w;
	logic [3:0][7:0] pwr_legal_w;
	logic [5:0][7:0] perf_r;
	logic [3:0][7:0] pwr_r;
	logic [7:0] speed_r;
	logic [7:0] layout_r;
	logic [7:0] layout_nxt;
	logic [7:0] speed_nxt;

	ecp_perf_filter u_perf (
		.raw_code(RAW_PERF),
		.minimum_throughput_code(perf_legal_w)
	);

	ecp_power_filter u_pwr (
		.raw_class(RAW_PWR),
		.hs52(HS52),
		.power_class_by_width(pwr_legal_w)
	);

	// Speed byte from capability, bit1 only with fast clock
	assign speed_nxt = HS52 ? ecp_pkg::SPEED_26_52 : ecp_pkg::SPEED_26; // see [R9] see [R10]

	// Reserved layout versions clamp to the newest defined one
	assign layout_nxt = (RAW_LAYOUT > ecp_pkg::LAYOUT_MAX) ? ecp_pkg::LAYOUT_MAX : RAW_LAYOUT; // see [R12]

	// Properties load after reset and never follow bus writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			perf_r <= {6{ecp_pkg::RST_BYTE}};
			pwr_r <= {4{ecp_pkg::RST_BYTE}};
			speed_r <= ecp_pkg::SPEED_26;
			layout_r <= ecp_pkg::RST_BYTE;
		end
		else
		begin
			perf_r <= perf_legal_w; // see [R15]
			pwr_r <= pwr_legal_w; // see [R6]
			speed_r <= speed_nxt;
			layout_r <= layout_nxt;
		end
	end

	// Layout version handed to the basic register as one indication
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			layout_version_ext <= ecp_pkg::RST_BYTE;
		else
			layout_version_ext <= layout_r; // see [R11]
	end

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic [9:0] idx;
	logic aligned;
	logic access;
	logic commit;
	logic [31:0] rd_nxt;
	logic err_nxt;
	logic wviol_r;
	logic wviol_set;
	logic wviol_clr;

	assign idx = paddr[11:2];
	assign aligned = (paddr[1:0] == 2'b00);
	assign access = psel && penable;
	assign commit = access && pready;

	// Read data and error for the current address
	always_comb
	begin
		rd_nxt = ecp_pkg::RST_WORD;
		err_nxt = 1'b0;
		if (!aligned)
			err_nxt = 1'b1;
		else if (idx < ecp_pkg::IDX_BLOCK_END)
		begin
			err_nxt = pwrite; // see [R15]
			case (idx)
				ecp_pkg::IDX_PERF_R_4_26: rd_nxt[7:0] = perf_r[0];
				ecp_pkg::IDX_PERF_W_4_26: rd_nxt[7:0] = perf_r[1];
				ecp_pkg::IDX_PERF_R_MID: rd_nxt[7:0] = perf_r[2];
				ecp_pkg::IDX_PERF_W_MID: rd_nxt[7:0] = perf_r[3];
				ecp_pkg::IDX_PERF_R_8_52: rd_nxt[7:0] = perf_r[4];
				ecp_pkg::IDX_PERF_W_8_52: rd_nxt[7:0] = perf_r[5];
				ecp_pkg::IDX_PWR_52_195: rd_nxt[7:0] = pwr_r[0];
				ecp_pkg::IDX_PWR_26_195: rd_nxt[7:0] = pwr_r[1];
				ecp_pkg::IDX_PWR_52_360: rd_nxt[7:0] = pwr_r[2];
				ecp_pkg::IDX_PWR_26_360: rd_nxt[7:0] = pwr_r[3];
				ecp_pkg::IDX_SPEED: rd_nxt[7:0] = speed_r;
				ecp_pkg::IDX_LAYOUT: rd_nxt[7:0] = layout_r;
				default: rd_nxt = ecp_pkg::RST_WORD; // see [R13]
			endcase
		end
		else if (idx == ecp_pkg::IDX_STATUS)
		begin
			err_nxt = pwrite;
			rd_nxt[ecp_pkg::STAT_WVIOL_BIT] = wviol_r;
		end
		else if (idx == ecp_pkg::IDX_CTRL)
			err_nxt = 1'b0;
		else
			err_nxt = 1'b1;
	end

	// One wait state: answer in the second access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= access && !pready;
	end

	// Read data and error captured with pready
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= ecp_pkg::RST_WORD;
			pslverr <= 1'b0;
		end
		else if (access && !pready)
		begin
			prdata <= pwrite ? ecp_pkg::RST_WORD : rd_nxt;
			pslverr <= err_nxt;
		end
		else
		begin
			prdata <= ecp_pkg::RST_WORD;
			pslverr <= 1'b0;
		end
	end

	// ----------------------------------------
	// Write violation flag
	// ----------------------------------------
	assign wviol_set = commit && pwrite && pslverr;
	assign wviol_clr = commit && pwrite && !pslverr && pwdata[ecp_pkg::CTRL_CLR_BIT];

	// Sticky refused-write flag, set wins over clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wviol_r <= ecp_pkg::RST_WVIOL;
		else if (wviol_set)
			wviol_r <= 1'b1; // see [R15]
		else if (wviol_clr)
			wviol_r <= 1'b0;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic any_hi;
	assign any_hi = (perf_r[0] > ecp_pkg::PERF_J) || (perf_r[1] > ecp_pkg::PERF_J) ||
		(perf_r[2] > ecp_pkg::PERF_J) || (perf_r[3] > ecp_pkg::PERF_J) ||
		(perf_r[4] > ecp_pkg::PERF_J) || (perf_r[5] > ecp_pkg::PERF_J);

	AST_PERF_LEGAL: assert property (@(posedge pclk) disable iff (!presetn) // see [R4]
		ecp_pkg::perf_legal(perf_r[0]) && ecp_pkg::perf_legal(perf_r[1]) &&
		ecp_pkg::perf_legal(perf_r[2]) && ecp_pkg::perf_legal(perf_r[3]) &&
		ecp_pkg::perf_legal(perf_r[4]) && ecp_pkg::perf_legal(perf_r[5]))
		else $error("illegal throughput code held");

	AST_MID_FLOOR: assert property (@(posedge pclk) disable iff (!presetn) // see [R3]
		any_hi |-> (perf_r[2] >= ecp_pkg::PERF_J) && (perf_r[3] >= ecp_pkg::PERF_J))
		else $error("mid category below floor");

	AST_LOW_FLOOR: assert property (@(posedge pclk) disable iff (!presetn) // see [R3]
		any_hi |-> (perf_r[0] >= ecp_pkg::PERF_E) && (perf_r[1] >= ecp_pkg::PERF_E))
		else $error("low category below floor");

	AST_PWR_RANGE: assert property (@(posedge pclk) disable iff (!presetn) // see [R7]
		(pwr_r[0][3:0] <= ecp_pkg::PWR_MAX) && (pwr_r[0][7:4] <= ecp_pkg::PWR_MAX) &&
		(pwr_r[1][3:0] <= ecp_pkg::PWR_MAX) && (pwr_r[1][7:4] <= ecp_pkg::PWR_MAX) &&
		(pwr_r[2][3:0] <= ecp_pkg::PWR_MAX) && (pwr_r[2][7:4] <= ecp_pkg::PWR_MAX) &&
		(pwr_r[3][3:0] <= ecp_pkg::PWR_MAX) && (pwr_r[3][7:4] <= ecp_pkg::PWR_MAX))
		else $error("reserved power class code");

	AST_NO52: assert property (@(posedge pclk) disable iff (!presetn) // see [R8]
		$past(presetn) && !HS52 |-> (pwr_r[0] == 8'h00) && (pwr_r[2] == 8'h00))
		else $error("fast clock power field set");

	AST_SPEED: assert property (@(posedge pclk) disable iff (!presetn) // see [R9]
		(speed_r == ecp_pkg::SPEED_26) || (speed_r == ecp_pkg::SPEED_26_52))
		else $error("speed byte out of set");

	AST_LAYOUT: assert property (@(posedge pclk) disable iff (!presetn) // see [R12]
		layout_r <= ecp_pkg::LAYOUT_MAX)
		else $error("reserved layout version");

	AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // see [R13]
		access && !pready && !pwrite && aligned && (idx == 10'h0c3) |=> pready && (prdata == 32'h0000_0000))
		else $error("reserved byte not zero");

	AST_RO_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // see [R15]
		access && !pready && pwrite && aligned && (idx == ecp_pkg::IDX_SPEED)
		|=> pready && pslverr ##1 wviol_r && $stable(speed_r))
		else $error("property write not refused");

	AST_ONE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(access) |=> pready ##1 !pready)
		else $error("answer timing off");

	// ----------------------------------------
	// Answer and field checks
	// ----------------------------------------
	// Answer pulse lasts one cycle
	AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("answer longer than one cycle");

	// Answer only follows an access cycle
	AST_READY_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
		pready |-> $past(access))
		else $error("answer without access");

	// Bus idles at zero between answers
	AST_IDLE_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> (prdata == ecp_pkg::RST_WORD) && !pslverr)
		else $error("answer lines not idle");

	// Writes never return data
	AST_WRITE_NO_DATA: assert property (@(posedge pclk) disable iff (!presetn)
		access && !pready && pwrite |=> prdata == ecp_pkg::RST_WORD)
		else $error("data returned on write");

	// Upper bits of every word read zero
	AST_UPPER_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // see [R13]
		prdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");

	// Aligned property reads are never refused
	AST_PROP_READ_OK: assert property (@(posedge pclk) disable iff (!presetn)
		access && !pready && !pwrite && aligned && (idx < ecp_pkg::IDX_BLOCK_END) |=> pready && !pslverr)
		else $error("property read refused");

	// Misaligned addresses are refused
	AST_MISALIGNED: assert property (@(posedge pclk) disable iff (!presetn)
		access && !pready && !aligned |=> pready && pslverr)
		else $error("misaligned access accepted");

	// Addresses past the control word are refused
	AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
		access && !pready && aligned && (idx > ecp_pkg::IDX_CTRL) |=> pready && pslverr)
		else $error("unmapped access accepted");

	// Control word reads back zero
	AST_CTRL_READ: assert property (@(posedge pclk) disable iff (!presetn)
		access && !pready && !pwrite && aligned && (idx == ecp_pkg::IDX_CTRL)
		|=> pready && !pslverr && (prdata == ecp_pkg::RST_WORD))
		else $error("control word not zero");

	// Status read shows the live flag
	AST_STATUS_READ: assert property (@(posedge pclk) disable iff (!presetn)
		commit && !pwrite && aligned && (idx == ecp_pkg::IDX_STATUS) |-> prdata[ecp_pkg::STAT_WVIOL_BIT] == wviol_r)
		else $error("status flag misreported");

	// Clear strobe drops the flag
	AST_FLAG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		wviol_clr && !wviol_set |=> !wviol_r)
		else $error("flag not cleared");

	// Flag moves only on a set or a clear
	AST_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		!wviol_set && !wviol_clr |=> wviol_r == $past(wviol_r))
		else $error("flag changed on its own");

	// Properties never move once loaded
	AST_PROPS_STABLE: assert property (@(posedge pclk) disable iff (!presetn) // see [R15]
		$past(presetn, 2) |-> $stable(perf_r) && $stable(pwr_r) && $stable(speed_r) && $stable(layout_r))
		else $error("property field changed");

	// Speed bits match the fast clock capability
	AST_SPEED_BITS: assert property (@(posedge pclk) disable iff (!presetn) // see [R10]
		$past(presetn) |-> (speed_r[0] == 1'b1) && (speed_r[1] == HS52) && (speed_r[7:2] == 6'h00))
		else $error("speed bits off");

	// Version handed on one cycle after the field
	AST_EXT_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn) // see [R11]
		$past(presetn) |-> layout_version_ext == $past(layout_r))
		else $error("version extension lags");

	// Back-to-back request starts at once
	COV_BACK_TO_BACK: cover property (@(posedge pclk) disable iff (!presetn)
		commit ##1 (psel && !penable));

	COV_READ_PERF: cover property (@(posedge pclk) disable iff (!presetn)
		commit && !pwrite && (idx == ecp_pkg::IDX_PERF_R_MID));
	COV_WRITE_REFUSED: cover property (@(posedge pclk) disable iff (!presetn)
		wviol_set);
	COV_FLAG_CLEARED: cover property (@(posedge pclk) disable iff (!presetn)
		wviol_r ##1 !wviol_r);
	COV_UNMAPPED: cover property (@(posedge pclk) disable iff (!presetn)
		commit && pslverr && !pwrite);

endmodule
`default_nettype wire
